// ### src/ext_irq_pkg.sv
// constants, field layouts and carriers for the external sensor irq logger
// assumes a single 20 MHz clock and a plain byte-addressed register port
package ext_irq_pkg;

   // ************************************
   // register byte offsets
   // ************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CAL_LO = 8'h04;
   localparam logic [7:0] ADDR_CAL_HI = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_STAMP = 8'h10;
   localparam logic [7:0] ADDR_RTC = 8'h14;
   localparam logic [7:0] ADDR_INTERVAL = 8'h18;

   // ************************************
   // control register fields
   // ************************************
   localparam int CTRL_FMT_LSB = 0;     // logging format [2:0]
   localparam int CTRL_BOTH_BIT = 3;    // irq plus timer together
   localparam int CTRL_SEL_LSB = 4;     // logged sensor select [1:0]
   localparam int CTRL_TIMER_BIT = 6;   // interval logging enable
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam int STAT_CLR_BIT = 0;     // write one clears pending

   // logging format codes that arm the comparators
   localparam logic [2:0] FMT_IRQ_ONE = 3'h5;
   localparam logic [2:0] FMT_IRQ_TWO = 3'h6;
   localparam logic [2:0] FMT_IRQ_BOTH = 3'h7;

   // logged sensor select codes
   localparam logic [1:0] SEL_TRIGGER = 2'h0;

   // threshold in percent of battery voltage per level code
   localparam logic [7:0] PCT_LVL0 = 8'h19;  // 25 percent
   localparam logic [7:0] PCT_LVL1 = 8'h08;  // 8 percent
   localparam logic [7:0] PCT_LVL2 = 8'h23;  // 35 percent
   localparam logic [7:0] PCT_LVL3 = 8'h2b;  // 43 percent

   // ************************************
   // timing
   // ************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int RTC_TICK_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * RTC_TICK_S;
   localparam logic [15:0] INTERVAL_RST = 16'h0001;

   // ************************************
   // calibration field, high word first
   // ************************************
   typedef struct packed {
      logic [7:0] pad;
      logic [1:0] rfu;
      logic exc_res;
      logic [3:0] bandgap_tc_trim;
      logic [6:0] temp_offset_trim;
      logic [4:0] sys_osc_trim;
      logic [1:0] irq_level;
      logic [1:0] high_cell_reset_level;
      logic sensor_supply_switch;
      logic [7:0] rtc_osc_trim;
      logic [4:0] main_ref_trim;
      logic [1:0] low_cell_reset_level;
      logic gnd_ref_select;
      logic [2:0] high_ref_coarse_trim;
      logic [4:0] high_ref_fine_trim;
      logic [2:0] low_ref_coarse_trim;
      logic [4:0] low_ref_fine_trim;
   } cal_t;

   // only the reference-ground select is set after reset
   localparam logic [63:0] CAL_RST = 64'h0000_0000_0001_0000;
   // pad and reserved bits stay zero
   localparam logic [31:0] CAL_HI_WMASK = 32'h003f_ffff;

   // one logged record
   typedef struct packed {
      logic [31:0] stamp;
      logic [1:0] sensors;
      logic [1:0] irq_src;
      logic timer_cause;
   } log_rec_t;

endpackage

// ### src/sensor_edge_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes the comparator output is asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module sensor_edge_sync
(
   input wire logic ref_clk_i,   // system clock
   input wire logic rst_i,       // async reset, high
   input wire logic async_i,     // comparator output
   output logic level_o,         // filtered level
   output logic rise_o           // one-cycle crossing pulse
);

   logic meta;
   logic stage2;
   logic stage3;
   logic level;

   // the first stage feeds only the second
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end
      else
      begin
         meta <= async_i;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         level <= 1'b0;
      else if (stage2 == stage3)
         level <= stage3;
   end

   assign level_o = level;
   assign rise_o = (stage2 == stage3) & stage3 & ~level;

endmodule
`default_nettype wire

// ### src/ext_sensor_irq_logging.sv
// external sensor interrupt logger with calibration field and rtc stamp
// assumes comparators outside, one 20 MHz clock, plain register port
//
// What this block does
// [RULE1] crossing raises wake request and logs stamp
// [RULE2] three-bit logging format selects irq mode
// [RULE3] format 101 arms sensor input one only
// [RULE4] format 110 arms sensor input two only
// [RULE5] format 111 arms both sensor inputs
// [RULE6] software picks which sensor gets logged
// [RULE7] one level selector shared by both inputs
// [RULE8] level codes map to 25/8/35/43 percent
// [RULE9] calibration field of trims, software modifiable
// [RULE10] reference-ground select defaults to one
// [RULE11] supply switch feeds battery to excitation
// [RULE12] software leaves factory trims untouched
// [RULE13] prepare flag lets irq and timer coexist
// [RULE14] synchronised edge gives one record per crossing
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ext_sensor_irq_logging
#(
   parameter int TICK_CYCLES = ext_irq_pkg::TICK_CYCLES,  // clocks per rtc second
   parameter int RTC_W = 32                               // rtc counter width
)
(
   input wire logic ref_clk_i,                  // 20 MHz clock
   input wire logic rst_i,                      // async reset, high
   input wire logic [7:0] addr_i,               // register byte address
   input wire logic [31:0] wdata_i,             // write data
   input wire logic wr_i,                       // write strobe
   input wire logic rd_i,                       // read strobe
   output logic [31:0] rdata_o,                 // read data, next cycle
   input wire logic cmp_one_i,                  // comparator, input one
   input wire logic cmp_two_i,                  // comparator, input two
   output logic irq_req_o,                      // wake request pulse
   output logic log_valid_o,                    // record strobe
   output ext_irq_pkg::log_rec_t log_rec_o,     // logged record
   output ext_irq_pkg::cal_t cal_o,             // calibration to analog
   output logic [7:0] thresh_pct_o,             // active threshold percent
   output logic exc_supply_o,                   // battery onto excitation
   output logic gnd_ref_o                       // low reference to ground
);

   // ************************************
   // elaboration checks
   // ************************************
   // a one-cycle second leaves the tick counter without any bits
   generate
      if (TICK_CYCLES < 2)
      begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2");
      end
      if (RTC_W < 1 || RTC_W > 32)
      begin : g_bad_rtc
         $error("RTC_W must lie in 1..32");
      end
   endgenerate

   // tick counter width; the last count wraps back to zero
   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // ************************************
   // register state
   // ************************************
   // software-visible state first, then counters and outputs
   logic [6:0] ctrl;
   logic [63:0] cal_bits;
   logic [15:0] interval;
   logic pending;
   logic [7:0] evt_cnt [2];
   logic [TW-1:0] tick_cnt;
   logic [RTC_W-1:0] rtc;
   logic [15:0] ival_cnt;
   logic irq_req;
   logic log_valid;
   ext_irq_pkg::log_rec_t log_rec;
   logic [31:0] rdata;

   // ************************************
   // register decode
   // ************************************
   // exact address match; unmapped offsets write nothing
   wire wr_ctrl = wr_i & (addr_i == ext_irq_pkg::ADDR_CTRL);
   wire wr_cal_lo = wr_i & (addr_i == ext_irq_pkg::ADDR_CAL_LO);
   wire wr_cal_hi = wr_i & (addr_i == ext_irq_pkg::ADDR_CAL_HI);
   wire wr_status = wr_i & (addr_i == ext_irq_pkg::ADDR_STATUS);
   wire wr_interval = wr_i & (addr_i == ext_irq_pkg::ADDR_INTERVAL);
   wire clr_pending = wr_status & wdata_i[ext_irq_pkg::STAT_CLR_BIT];

   // control fields split out by position
   wire [2:0] log_fmt = ctrl[ext_irq_pkg::CTRL_FMT_LSB +: 3];
   wire both_en = ctrl[ext_irq_pkg::CTRL_BOTH_BIT];
   wire [1:0] log_sel = ctrl[ext_irq_pkg::CTRL_SEL_LSB +: 2];
   wire timer_en = ctrl[ext_irq_pkg::CTRL_TIMER_BIT];
   // typed view of the field for the analog side
   ext_irq_pkg::cal_t cal;
   assign cal = ext_irq_pkg::cal_t'(cal_bits);

   // control register, written by the set-log-format path
   // [RULE2] format field stored
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl <= ext_irq_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl <= wdata_i[6:0];
   end

   // calibration field, two words; pad and reserved bits never stick
   // [RULE9] trims held writable
   // [RULE10] ground select resets set
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cal_bits <= ext_irq_pkg::CAL_RST;
      else if (wr_cal_lo)
         cal_bits[31:0] <= wdata_i;
      else if (wr_cal_hi)
         cal_bits[63:32] <= wdata_i & ext_irq_pkg::CAL_HI_WMASK;
   end

   // timer interval in rtc seconds; zero behaves as every second
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         interval <= ext_irq_pkg::INTERVAL_RST;
      else if (wr_interval)
         interval <= wdata_i[15:0];
   end

   // ************************************
   // comparator inputs
   // ************************************
   // bit 0 is sensor input one, bit 1 sensor input two
   wire [1:0] cmp_async = {cmp_two_i, cmp_one_i};
   logic [1:0] cmp_level;
   logic [1:0] cmp_rise;

   // [RULE14] synchronise, edge detect
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_sync
         sensor_edge_sync u_sync
         (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .async_i(cmp_async[i]),
            .level_o(cmp_level[i]),
            .rise_o(cmp_rise[i])
         );
      end
   endgenerate

   // arming mask from the logging format; other codes arm nothing
   // a stray code must never wake the system
   // [RULE3] input one only
   // [RULE4] input two only
   // [RULE5] either input
   wire [1:0] arm_mask =
      (log_fmt == ext_irq_pkg::FMT_IRQ_ONE) ? 2'h1 :
      (log_fmt == ext_irq_pkg::FMT_IRQ_TWO) ? 2'h2 :
      (log_fmt == ext_irq_pkg::FMT_IRQ_BOTH) ? 2'h3 : 2'h0;
   wire irq_mode = (arm_mask != 2'h0);
   wire [1:0] irq_hit = cmp_rise & arm_mask;
   wire any_hit = |irq_hit;

   // ************************************
   // threshold level to analog
   // ************************************
   // [RULE7] single shared selector
   // [RULE8] code to percent
   wire [7:0] pct_sel =
      (cal.irq_level == 2'h0) ? ext_irq_pkg::PCT_LVL0 :
      (cal.irq_level == 2'h1) ? ext_irq_pkg::PCT_LVL1 :
      (cal.irq_level == 2'h2) ? ext_irq_pkg::PCT_LVL2 : ext_irq_pkg::PCT_LVL3;

   // registered so the analog threshold moves on a clean edge
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         thresh_pct_o <= ext_irq_pkg::PCT_LVL0;
      else
         thresh_pct_o <= pct_sel;
   end

   // ************************************
   // real-time clock and interval timer
   // ************************************
   // a one-cycle enable; no second clock exists
   wire sec_tick = (tick_cnt == TICK_LAST);

   // one-second enable from the reference clock
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         tick_cnt <= '0;
      else if (sec_tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + TW'(1);
   end

   // seconds counter; wraps silently at full width
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rtc <= '0;
      else if (sec_tick)
         rtc <= rtc + RTC_W'(1);
   end

   // irq formats suppress interval logging unless the prepare flag allows both
   // [RULE13] parallel irq and timer
   wire timer_allowed = timer_en & (~irq_mode | both_en);
   wire ival_due = ({1'b0, ival_cnt} + 17'h00001) >= {1'b0, interval};
   wire timer_fire = sec_tick & timer_allowed & ival_due;

   // whole seconds; restarts whenever the timer is held off
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ival_cnt <= '0;
      else if (~timer_allowed)
         ival_cnt <= '0;
      else if (sec_tick)
         ival_cnt <= ival_due ? 16'h0000 : ival_cnt + 16'h0001;
   end

   // ************************************
   // wake request and record
   // ************************************
   // registered pulse, one cycle per accepted crossing
   // [RULE1] wake on crossing
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_req <= 1'b0;
      else
         irq_req <= any_hit;
   end

   // logged sensors: the triggering input, or the software choice
   // a timer-only record under trigger select names both inputs
   // [RULE6] selectable logged sensor
   wire [1:0] trig_sensors = any_hit ? irq_hit : 2'h3;
   wire [1:0] next_sensors = (log_sel == ext_irq_pkg::SEL_TRIGGER) ? trig_sensors : log_sel;
   wire rec_fire = any_hit | timer_fire;

   // a coincident timer tick folds into the same record
   // [RULE1] stamp with rtc
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         log_valid <= 1'b0;
         log_rec <= '0;
      end
      else
      begin
         log_valid <= rec_fire;
         if (rec_fire)
         begin
            log_rec.stamp <= 32'(rtc);
            log_rec.sensors <= next_sensors;
            log_rec.irq_src <= irq_hit;
            log_rec.timer_cause <= timer_fire;
         end
      end
   end

   // ************************************
   // status
   // ************************************
   // a new record in the clearing cycle keeps the flag set
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pending <= 1'b0;
      else if (rec_fire)
         pending <= 1'b1;
      else if (clr_pending)
         pending <= 1'b0;
   end

   // per-input event counters, wrapping, for pulse counting
   // [RULE14] one count per crossing
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_cnt
         always_ff @(posedge ref_clk_i or posedge rst_i)
         begin
            if (rst_i)
               evt_cnt[i] <= 8'h00;
            else if (irq_hit[i])
               evt_cnt[i] <= evt_cnt[i] + 8'h01;
         end
      end
   endgenerate

   // ************************************
   // read path
   // ************************************
   // counts, filtered levels, last source, pending flag
   wire [31:0] status_word = {8'h00, evt_cnt[1], evt_cnt[0], 3'h0, cmp_level, log_rec.irq_src,
                              pending};
   // a gap in the map reads as zero rather than aliasing
   wire [31:0] rd_mux =
      (addr_i == ext_irq_pkg::ADDR_CTRL) ? {25'h0, ctrl} :
      (addr_i == ext_irq_pkg::ADDR_CAL_LO) ? cal_bits[31:0] :
      (addr_i == ext_irq_pkg::ADDR_CAL_HI) ? cal_bits[63:32] :
      (addr_i == ext_irq_pkg::ADDR_STATUS) ? status_word :
      (addr_i == ext_irq_pkg::ADDR_STAMP) ? log_rec.stamp :
      (addr_i == ext_irq_pkg::ADDR_RTC) ? 32'(rtc) :
      (addr_i == ext_irq_pkg::ADDR_INTERVAL) ? {16'h0, interval} : 32'h0000_0000;

   // data valid only in the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata <= 32'h0000_0000;
      else
         rdata <= rd_i ? rd_mux : 32'h0000_0000;
   end

   // ************************************
   // outputs
   // ************************************
   // calibration bits leave unregistered, straight from the field
   // [RULE11] supply switch drives excitation
   assign exc_supply_o = cal.sensor_supply_switch;
   // [RULE10] ground select to converter
   assign gnd_ref_o = cal.gnd_ref_select;
   assign cal_o = cal;
   assign irq_req_o = irq_req;
   assign log_valid_o = log_valid;
   assign log_rec_o = log_rec;
   assign rdata_o = rdata;

endmodule
`default_nettype wire

// ### bench/ext_irq_props.sv
// checker for the external sensor irq logger, top ports only
// assumes one clock domain; bound into every logger instance
`timescale 1ns/1ps
`default_nettype none
module ext_irq_props
#(
   parameter int TICK_CYCLES = 8,  // clocks per rtc second
   parameter int RTC_W = 32        // rtc width
)
(
   input wire logic ref_clk_i,                // clock
   input wire logic rst_i,                    // reset
   input wire logic [7:0] addr_i,             // address
   input wire logic [31:0] wdata_i,           // write data
   input wire logic wr_i,                     // write strobe
   input wire logic rd_i,                     // read strobe
   input wire logic [31:0] rdata_o,           // read data
   input wire logic cmp_one_i,                // comparator one
   input wire logic cmp_two_i,                // comparator two
   input wire logic irq_req_o,                // wake pulse
   input wire logic log_valid_o,              // record strobe
   input wire ext_irq_pkg::log_rec_t log_rec_o, // record
   input wire ext_irq_pkg::cal_t cal_o,       // calibration
   input wire logic [7:0] thresh_pct_o,       // threshold
   input wire logic exc_supply_o,             // supply switch
   input wire logic gnd_ref_o                 // ground ref
);
   // ************************************
   // shadow state and assertions
   // ************************************
   logic [2:0] fmt;
   logic [1:0] prev_lvl;
   wire logic arm_one;
   wire logic arm_two;
   wire logic [7:0] exp_pct;
   // format codes that arm each input
   assign arm_one = (fmt == 3'h5) || (fmt == 3'h7);
   assign arm_two = (fmt == 3'h6) || (fmt == 3'h7);
   assign exp_pct = prev_lvl[1] ? (prev_lvl[0] ? 8'h2b : 8'h23) : (prev_lvl[0] ? 8'h08 : 8'h19);
   // shadow of format; threshold lags the level by one edge
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fmt <= 3'h0;
         prev_lvl <= 2'h0;
      end
      else
      begin
         if (wr_i && addr_i == ext_irq_pkg::ADDR_CTRL)
            fmt <= wdata_i[2:0];
         prev_lvl <= cal_o.irq_level;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_THRESH: assert property (thresh_pct_o == exp_pct)
      else $error("threshold percent wrong for level code");
   AST_RISE_ONE: assert property ($rose(cmp_one_i) && arm_one |-> ##4 irq_req_o)
      else $error("armed input one gave no wake pulse");
   AST_RISE_TWO: assert property ($rose(cmp_two_i) && arm_two |-> ##4 irq_req_o)
      else $error("armed input two gave no wake pulse");
   AST_UNARMED: assert property (irq_req_o |-> arm_one || arm_two)
      else $error("wake pulse with no armed format");
   AST_SRC_ONE: assert property (irq_req_o && log_rec_o.irq_src[0]
      |-> arm_one && $past(cmp_one_i, 4) && !$past(cmp_one_i, 5))
      else $error("source one without its crossing");
   AST_LOGS: assert property (irq_req_o |-> log_valid_o && log_rec_o.irq_src != 2'h0)
      else $error("wake pulse without a record");
   AST_ONE_PULSE: assert property (irq_req_o |=> !irq_req_o)
      else $error("wake pulse longer than one cycle");
   AST_CAL_HI: assert property (wr_i && addr_i == ext_irq_pkg::ADDR_CAL_HI
      |=> cal_o[63:32] == ($past(wdata_i) & ext_irq_pkg::CAL_HI_WMASK))
      else $error("calibration high word not written");
   AST_SUPPLY: assert property (exc_supply_o == cal_o.sensor_supply_switch)
      else $error("supply output differs from its bit");
   AST_GND: assert property (gnd_ref_o == cal_o.gnd_ref_select)
      else $error("ground reference differs from its bit");
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its cycle");
endmodule
bind ext_sensor_irq_logging ext_irq_props #(.TICK_CYCLES(TICK_CYCLES), .RTC_W(RTC_W)) props_inst
(
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_one_i(cmp_one_i),
   .cmp_two_i(cmp_two_i), .irq_req_o(irq_req_o), .log_valid_o(log_valid_o),
   .log_rec_o(log_rec_o), .cal_o(cal_o), .thresh_pct_o(thresh_pct_o),
   .exc_supply_o(exc_supply_o), .gnd_ref_o(gnd_ref_o)
);
`default_nettype wire

// ### bench/sensor_pins_model.sv
// two external pulse sensors seen through their comparators
// assumes the bench calls set_volt just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sensor_pins_model
(
   input wire logic ref_clk_i,          // clock
   input wire logic [7:0] thresh_pct_i, // threshold percent
   output logic cmp_one_o,              // comparator one
   output logic cmp_two_o               // comparator two
);
   logic [7:0] volt_one = 8'h00;
   logic [7:0] volt_two = 8'h00;
   // sensor levels in percent of battery
   task automatic set_volt(input logic [7:0] v1, input logic [7:0] v2);
      volt_one <= v1;
      volt_two <= v2;
   endtask
   // comparators switch on the edge, so crossings are setup-ideal
   // outputs settle at the first edge, well inside reset
   always @(posedge ref_clk_i)
   begin
      cmp_one_o <= volt_one > thresh_pct_i;
      cmp_two_o <= volt_two > thresh_pct_i;
   end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the external sensor irq logger
// assumes the sensor model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int LIMIT = 5000;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic cmp_one_i, cmp_two_i, irq_req_o, log_valid_o, exc_supply_o, gnd_ref_o;
   ext_irq_pkg::log_rec_t log_rec_o;
   ext_irq_pkg::cal_t cal_o;
   logic [7:0] thresh_pct_o;
   int err_count = 0, n_checks = 0, n_rec = 0, n_tmr = 0, cycles = 0;
   logic [1:0] last_src = 2'h0, last_sens = 2'h0;
   logic [7:0] pct_tab [4] = '{8'h19, 8'h08, 8'h23, 8'h2b};
   logic [2:0] fmts [5] = '{3'h5, 3'h6, 3'h7, 3'h0, 3'h4};
   always #25 ref_clk_i = ~ref_clk_i;
   // short rtc second keeps the timer test brief
   ext_sensor_irq_logging #(.TICK_CYCLES(8)) ext_sensor_irq_logging_inst
   (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_one_i(cmp_one_i),
      .cmp_two_i(cmp_two_i), .irq_req_o(irq_req_o), .log_valid_o(log_valid_o),
      .log_rec_o(log_rec_o), .cal_o(cal_o), .thresh_pct_o(thresh_pct_o),
      .exc_supply_o(exc_supply_o), .gnd_ref_o(gnd_ref_o)
   );
   sensor_pins_model sensor_pins_model_inst
   (
      .ref_clk_i(ref_clk_i), .thresh_pct_i(thresh_pct_o),
      .cmp_one_o(cmp_one_i), .cmp_two_o(cmp_two_i)
   );
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // record watcher and hang guard
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (log_valid_o === 1'b1)
      begin
         n_rec++;
         n_tmr += (log_rec_o.timer_cause === 1'b1);
         last_src = log_rec_o.irq_src;
         last_sens = log_rec_o.sensors;
      end
      if (cycles == LIMIT)
      begin
         err_count++;
         print_verdict();
      end
   end
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_count(input string name, input int exp, input int got);
      n_checks++;
      if (got != exp)
      begin
         err_count++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(posedge ref_clk_i);
      d = rdata_o;
   endtask
   // one sensor pulse of eight cycles, then count its records
   task automatic fire(input logic [7:0] v1, input logic [7:0] v2, input int exp_n);
      int r0;
      r0 = n_rec;
      @(posedge ref_clk_i);
      sensor_pins_model_inst.set_volt(v1, v2);
      repeat (8) @(posedge ref_clk_i);
      sensor_pins_model_inst.set_volt(8'h00, 8'h00);
      repeat (10) @(posedge ref_clk_i);
      chk_count("records", exp_n, n_rec - r0);
   endtask
   initial
   begin
      logic [31:0] d;
      int r0;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      reg_rd(ext_irq_pkg::ADDR_CAL_LO, d);
      chk_word("cal low reset", 32'h0001_0000, d);
      reg_rd(ext_irq_pkg::ADDR_CAL_HI, d);
      chk_word("cal high reset", 32'h0, d);
      chk_word("threshold reset", 32'h19, {24'h0, thresh_pct_o});
      reg_rd(8'h1c, d);
      chk_word("unmapped read", 32'h0, d);
      reg_wr(ext_irq_pkg::ADDR_CAL_HI, 32'hffff_ffff);
      reg_rd(ext_irq_pkg::ADDR_CAL_HI, d);
      chk_word("cal high mask", 32'h003f_ffff, d);
      chk_word("supply switch", 32'h1, {31'h0, exc_supply_o});
      reg_wr(ext_irq_pkg::ADDR_CAL_LO, 32'ha5c2_5a3c);
      reg_rd(ext_irq_pkg::ADDR_CAL_LO, d);
      chk_word("cal low", 32'ha5c2_5a3c, d);
      chk_word("ground ref", 32'h0, {31'h0, gnd_ref_o});
      reg_wr(ext_irq_pkg::ADDR_CAL_LO, 32'h0001_0000);
      $display("test calibration done");
      // each level code, 30 percent on both inputs in turn
      reg_wr(ext_irq_pkg::ADDR_CTRL, 32'h7);
      for (int lvl = 0; lvl < 4; lvl++)
      begin
         reg_wr(ext_irq_pkg::ADDR_CAL_HI, 32'(lvl) << 3);
         // threshold register follows the level code one edge later
         @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         chk_word("threshold", {24'h0, pct_tab[lvl]}, {24'h0, thresh_pct_o});
         fire(8'h1e, 8'h00, (8'h1e > pct_tab[lvl]) ? 1 : 0);
         fire(8'h00, 8'h1e, (8'h1e > pct_tab[lvl]) ? 1 : 0);
      end
      $display("test levels done");
      reg_wr(ext_irq_pkg::ADDR_CAL_HI, 32'h0);
      foreach (fmts[i])
      begin
         reg_wr(ext_irq_pkg::ADDR_CTRL, {29'h0, fmts[i]});
         fire(8'h32, 8'h00, (fmts[i] == 3'h5 || fmts[i] == 3'h7) ? 1 : 0);
         fire(8'h00, 8'h32, (fmts[i] == 3'h6 || fmts[i] == 3'h7) ? 1 : 0);
      end
      reg_wr(ext_irq_pkg::ADDR_CTRL, 32'h7);
      fire(8'h32, 8'h32, 1);
      chk_word("both sources", 32'h3, {30'h0, last_src});
      $display("test formats done");
      for (int s = 0; s < 4; s++)
      begin
         reg_wr(ext_irq_pkg::ADDR_CTRL, (32'(s) << 4) | 32'h7);
         fire(8'h00, 8'h32, 1);
         chk_word("logged sensors", (s == 0) ? 32'h2 : 32'(s), {30'h0, last_sens});
      end
      $display("test sensor select done");
      reg_wr(ext_irq_pkg::ADDR_CTRL, 32'h45);
      r0 = n_tmr;
      repeat (40) @(posedge ref_clk_i);
      chk_count("timer held off", 0, n_tmr - r0);
      reg_wr(ext_irq_pkg::ADDR_CTRL, 32'h4d);
      r0 = n_tmr;
      repeat (40) @(posedge ref_clk_i);
      chk_count("timer with irq", 1, (n_tmr - r0 >= 3 && n_tmr - r0 <= 6) ? 1 : 0);
      reg_wr(ext_irq_pkg::ADDR_CTRL, 32'h0);
      reg_rd(ext_irq_pkg::ADDR_STATUS, d);
      chk_word("pending set", 32'h1, {31'h0, d[0]});
      chk_word("event counts", 32'h0905, {16'h0, d[23:8]});
      reg_wr(ext_irq_pkg::ADDR_STATUS, 32'h1);
      reg_rd(ext_irq_pkg::ADDR_STATUS, d);
      chk_word("pending cleared", 32'h0, {31'h0, d[0]});
      $display("test timer done");
      print_verdict();
   end
endmodule
`default_nettype wire
